// File: hdl/upg_regs.vh
// Contract
// - Completed character goes to holding register, ready set
// - Character while ready set: overrun, overwrite held
// - Clear-status command clears overrun, parity, stop errors
// - Parity select: even, odd, mark, space, none, multidrop
// - Even parity: bit equals XOR of data
// - Odd parity: bit equals inverted XOR of data
// - Mark parity: send 1, error on 0
// - Space parity: send 0, error on 1
// - No parity: bit omitted, never an error
// - Parity error flag sticky until clear command
// - Multidrop: data parity 0, address parity 1
// - Multidrop receive: high parity bit flags parity error
// - Send-address command marks next written byte as address
// - Guard count nonzero holds line high after stop
// - Holding-free stays low through guard until start bit
// - All-idle stays low until guard period ends
// - Idle reload zero disables timeout, flag stays 0
// - Idle counter decrements per bit, reloads per character
// - Arm-idle-wait stops counter until next character
// - Reload-idle-count restarts countdown from reload value
// - Stop bit sampled 0 sets stop-bit error flag
`ifndef UPG_REGS_VH
`define UPG_REGS_VH

// ***************************************
// Register byte offsets
// ***************************************
`define UPG_OFF_CTRL     5'h0_0
`define UPG_OFF_MODE     5'h0_4
`define UPG_OFF_STATUS   5'h0_8
`define UPG_OFF_RHR      5'h0_C
`define UPG_OFF_THR      5'h1_0
`define UPG_OFF_GUARD    5'h1_4
`define UPG_OFF_IDLE     5'h1_8

// ***************************************
// Control command bits
// ***************************************
`define UPG_CMD_CLR_STATUS 0
`define UPG_CMD_SEND_ADDR  1
`define UPG_CMD_ARM_IDLE   2
`define UPG_CMD_RELOAD     3

// ***************************************
// Status bits
// ***************************************
`define UPG_ST_RX_READY   0
`define UPG_ST_TX_FREE    1
`define UPG_ST_OVERRUN    2
`define UPG_ST_STOP_ERR   3
`define UPG_ST_PAR_ERR    4
`define UPG_ST_IDLE_EXP   5
`define UPG_ST_TX_IDLE    6

// ***************************************
// Parity select codes
// ***************************************
`define UPG_PAR_EVEN    3'h0
`define UPG_PAR_ODD     3'h1
`define UPG_PAR_SPACE   3'h2
`define UPG_PAR_MARK    3'h3
`define UPG_PAR_NONE    3'h4
`define UPG_PAR_MDROP0  3'h6
`define UPG_PAR_MDROP1  3'h7

// ***************************************
// Reset values and answers
// ***************************************
`define UPG_RST_MODE    3'h4
`define UPG_RESP_OKAY   2'h0
`define UPG_RESP_SLVERR 2'h2

`endif

// File: hdl/upg_usart.v
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "upg_regs.vh"

module upg_usart (
   // Clock and reset
   input  wire        core_clk_in,
   input  wire        reset_in,
   // Bit period strobe from the baud generator
   input  wire        bit_tick_in,
   // Serial lines
   input  wire        rxd_in,
   output reg         txd_out,
   // AXI4-Lite write address
   input  wire        s_axi_awvalid_in,
   output reg         s_axi_awready_out,
   input  wire [4:0]  s_axi_awaddr_in,
   // AXI4-Lite write data
   input  wire        s_axi_wvalid_in,
   output reg         s_axi_wready_out,
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   // AXI4-Lite write response
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   output reg  [1:0]  s_axi_bresp_out,
   // AXI4-Lite read address
   input  wire        s_axi_arvalid_in,
   output reg         s_axi_arready_out,
   input  wire [4:0]  s_axi_araddr_in,
   // AXI4-Lite read data
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out
);

   // ***************************************
   // State codes
   // ***************************************
   localparam [2:0] TX_IDLE  = 3'h0;
   localparam [2:0] TX_DATA  = 3'h1;
   localparam [2:0] TX_PAR   = 3'h2;
   localparam [2:0] TX_STOP  = 3'h3;
   localparam [2:0] TX_GUARD = 3'h4;
   localparam [1:0] RX_IDLE  = 2'h0;
   localparam [1:0] RX_DATA  = 2'h1;
   localparam [1:0] RX_PAR   = 2'h2;
   localparam [1:0] RX_STOP  = 2'h3;

   // ***************************************
   // Registers
   // ***************************************
   reg  [2:0]  parity_select_ff;    // Parity mode
   reg  [7:0]  guard_bit_count_ff;  // Guard periods
   reg  [15:0] idle_reload_ff;      // Idle reload value
   reg  [7:0]  rhr_ff;              // Receive holding register
   reg  [7:0]  thr_ff;              // Transmit holding register
   reg         thr_full_ff;         // Byte waiting in holding reg
   reg         thr_addr_ff;         // Waiting byte is an address
   reg         send_addr_ff;        // Next write is an address
   reg         rx_ready_ff;         // Received character ready
   reg         overrun_ff;          // Overrun flag
   reg         par_err_ff;          // Parity error flag
   reg         stop_err_ff;         // Stop-bit error flag
   reg         idle_exp_ff;         // Idle timeout expired
   reg  [15:0] idle_cnt_ff;         // Idle countdown
   reg         idle_run_ff;         // Idle counter clock running
   // Transmitter
   reg  [2:0]  tx_state_ff;
   reg  [7:0]  tx_shift_ff;
   reg  [2:0]  tx_bit_ff;
   reg         tx_par_ff;
   reg  [7:0]  tx_guard_ff;
   // Receiver
   reg  [1:0]  rx_state_ff;
   reg  [7:0]  rx_shift_ff;
   reg  [2:0]  rx_bit_ff;
   reg         rx_par_ff;
   // Bus slave
   reg         aw_held_ff;
   reg  [4:0]  aw_addr_ff;
   reg         w_held_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0]  w_strb_ff;

   // ***************************************
   // Decoded events
   // ***************************************
   wire wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid_out;
   wire rd_go = s_axi_arvalid_in & s_axi_arready_out;
   wire wr_ctrl = wr_go & (aw_addr_ff == `UPG_OFF_CTRL) & w_strb_ff[0];
   wire cmd_clr = wr_ctrl & w_data_ff[`UPG_CMD_CLR_STATUS];
   wire cmd_addr = wr_ctrl & w_data_ff[`UPG_CMD_SEND_ADDR];
   wire cmd_arm = wr_ctrl & w_data_ff[`UPG_CMD_ARM_IDLE];
   wire cmd_reload = wr_ctrl & w_data_ff[`UPG_CMD_RELOAD];
   wire wr_thr = wr_go & (aw_addr_ff == `UPG_OFF_THR) & w_strb_ff[0];
   wire rd_rhr = rd_go & (s_axi_araddr_in == `UPG_OFF_RHR);
   wire par_on = (parity_select_ff != `UPG_PAR_NONE) &
                 (parity_select_ff != 3'h5);
   wire mdrop = (parity_select_ff == `UPG_PAR_MDROP0) |
                (parity_select_ff == `UPG_PAR_MDROP1);
   wire rx_done = bit_tick_in & (rx_state_ff == RX_STOP);
   // Transmitter may start a new character at this tick
   wire tx_open = (tx_state_ff == TX_IDLE) |
                  ((tx_state_ff == TX_GUARD) & (tx_guard_ff == 8'h0_0));

   // Parity bit for a data byte in the current mode
   function par_of;
      input [7:0] data;
      input [2:0] mode;
      input       addr;
      begin
         case (mode)
            `UPG_PAR_EVEN:   par_of = ^data;
            `UPG_PAR_ODD:    par_of = ~^data;
            `UPG_PAR_MARK:   par_of = 1'b1;
            `UPG_PAR_SPACE:  par_of = 1'b0;
            `UPG_PAR_MDROP0,
            `UPG_PAR_MDROP1: par_of = addr;
            default:         par_of = 1'b0;
         endcase
      end
   endfunction

   // Receive parity check result
   wire rx_par_bad = mdrop ? rx_par_ff
                   : (rx_par_ff != par_of(rx_shift_ff, parity_select_ff,
                                          1'b0));

   // ***************************************
   // AXI4-Lite slave
   // ***************************************
   // Address and data taken in either order; one write at a time
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= `UPG_RESP_OKAY;
         aw_held_ff        <= 1'b0;
         w_held_ff         <= 1'b0;
         aw_addr_ff        <= 5'h0_0;
         w_data_ff         <= 32'h0000_0000;
         w_strb_ff         <= 4'h0;
      end else begin
         // Ready pulses for one cycle, only while its own channel holds nothing
         s_axi_awready_out <= s_axi_awvalid_in & ~s_axi_awready_out &
                              ~aw_held_ff;
         s_axi_wready_out  <= s_axi_wvalid_in & ~s_axi_wready_out &
                              ~w_held_ff;
         if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata_in;
            w_strb_ff <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            aw_held_ff       <= 1'b0;
            w_held_ff        <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            // Status and receive holding registers are read only
            s_axi_bresp_out  <= (aw_addr_ff[1:0] != 2'h0 ||
                                 aw_addr_ff > `UPG_OFF_IDLE ||
                                 aw_addr_ff == `UPG_OFF_STATUS ||
                                 aw_addr_ff == `UPG_OFF_RHR) ?
                                `UPG_RESP_SLVERR : `UPG_RESP_OKAY;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // Read channel: one cycle address, data the cycle after
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= `UPG_RESP_OKAY;
      end else begin
         s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out &
                              ~s_axi_rvalid_out;
         if (rd_go) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= `UPG_RESP_OKAY;
            case (s_axi_araddr_in)
               `UPG_OFF_MODE:   s_axi_rdata_out <= {29'h0, parity_select_ff};
               `UPG_OFF_STATUS: s_axi_rdata_out <= {25'h0,
                                  (tx_state_ff == TX_IDLE) & ~thr_full_ff,
                                  idle_exp_ff, par_err_ff, stop_err_ff,
                                  overrun_ff, ~thr_full_ff, rx_ready_ff};
               `UPG_OFF_RHR:    s_axi_rdata_out <= {24'h0, rhr_ff};
               `UPG_OFF_GUARD:  s_axi_rdata_out <= {24'h0,
                                                    guard_bit_count_ff};
               `UPG_OFF_IDLE:   s_axi_rdata_out <= {16'h0, idle_reload_ff};
               `UPG_OFF_CTRL,
               `UPG_OFF_THR:    s_axi_rdata_out <= 32'h0000_0000;
               default: begin
                  s_axi_rdata_out <= 32'h0000_0000;
                  s_axi_rresp_out <= `UPG_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // ***************************************
   // Configuration registers
   // ***************************************
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         parity_select_ff   <= `UPG_RST_MODE;
         guard_bit_count_ff <= 8'h0_0;
         idle_reload_ff     <= 16'h0000;
      end else if (wr_go) begin
         // Each byte lane lands only with its strobe
         if (aw_addr_ff == `UPG_OFF_MODE && w_strb_ff[0]) begin
            parity_select_ff <= w_data_ff[2:0];
         end
         if (aw_addr_ff == `UPG_OFF_GUARD && w_strb_ff[0]) begin
            guard_bit_count_ff <= w_data_ff[7:0];
         end
         if (aw_addr_ff == `UPG_OFF_IDLE && w_strb_ff[0]) begin
            idle_reload_ff[7:0] <= w_data_ff[7:0];
         end
         if (aw_addr_ff == `UPG_OFF_IDLE && w_strb_ff[1]) begin
            idle_reload_ff[15:8] <= w_data_ff[15:8];
         end
      end
   end

   // ***************************************
   // Transmitter
   // ***************************************
   // Holding register: a load at the start bit frees it
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         thr_full_ff  <= 1'b0;
         thr_ff       <= 8'h0_0;
         thr_addr_ff  <= 1'b0;
         send_addr_ff <= 1'b0;
      end else begin
         if (cmd_addr) begin
            send_addr_ff <= 1'b1;
         end
         if (bit_tick_in & tx_open & thr_full_ff) begin
            thr_full_ff <= 1'b0;
         end
         // Write while full replaces the waiting byte
         if (wr_thr) begin
            thr_full_ff  <= 1'b1;
            thr_ff       <= w_data_ff[7:0];
            thr_addr_ff  <= send_addr_ff | cmd_addr;
            send_addr_ff <= 1'b0;
         end
      end
   end

   // Line sequencer: each state names what goes out at next tick
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         tx_state_ff <= TX_IDLE;
         txd_out     <= 1'b1;
         tx_shift_ff <= 8'h0_0;
         tx_bit_ff   <= 3'h0;
         tx_par_ff   <= 1'b0;
         tx_guard_ff <= 8'h0_0;
      end else if (bit_tick_in) begin
         case (tx_state_ff)
            TX_DATA: begin
               txd_out     <= tx_shift_ff[0];
               tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
               tx_bit_ff   <= tx_bit_ff + 3'h1;
               if (tx_bit_ff == 3'h7) begin
                  tx_state_ff <= par_on ? TX_PAR : TX_STOP;
               end
            end
            TX_PAR: begin
               txd_out     <= tx_par_ff;
               tx_state_ff <= TX_STOP;
            end
            TX_STOP: begin
               txd_out     <= 1'b1;
               tx_guard_ff <= guard_bit_count_ff;
               // Zero count skips the guard entirely
               tx_state_ff <= (guard_bit_count_ff == 8'h0_0) ?
                              TX_IDLE : TX_GUARD;
            end
            TX_IDLE, TX_GUARD: begin
               if (tx_guard_ff != 8'h0_0) begin
                  // Line stays high, still part of this character
                  tx_guard_ff <= tx_guard_ff - 8'h0_1;
               end else if (thr_full_ff) begin
                  txd_out     <= 1'b0;
                  tx_shift_ff <= thr_ff;
                  tx_bit_ff   <= 3'h0;
                  tx_par_ff   <= par_of(thr_ff, parity_select_ff,
                                        thr_addr_ff);
                  tx_state_ff <= TX_DATA;
               end else begin
                  tx_state_ff <= TX_IDLE;
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // ***************************************
   // Receiver
   // ***************************************
   // Ticks are taken as mid-bit sample points
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         rx_state_ff <= RX_IDLE;
         rx_shift_ff <= 8'h0_0;
         rx_bit_ff   <= 3'h0;
         rx_par_ff   <= 1'b0;
      end else if (bit_tick_in) begin
         case (rx_state_ff)
            RX_IDLE: begin
               if (!rxd_in) begin
                  rx_state_ff <= RX_DATA;
                  rx_bit_ff   <= 3'h0;
               end
            end
            RX_DATA: begin
               rx_shift_ff <= {rxd_in, rx_shift_ff[7:1]};
               rx_bit_ff   <= rx_bit_ff + 3'h1;
               if (rx_bit_ff == 3'h7) begin
                  rx_state_ff <= par_on ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               rx_par_ff   <= rxd_in;
               rx_state_ff <= RX_STOP;
            end
            RX_STOP: rx_state_ff <= RX_IDLE;
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   // Sticky flags: a set in the clear cycle wins
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         rhr_ff      <= 8'h0_0;
         rx_ready_ff <= 1'b0;
         overrun_ff  <= 1'b0;
         par_err_ff  <= 1'b0;
         stop_err_ff <= 1'b0;
      end else begin
         rx_ready_ff <= (rx_ready_ff & ~rd_rhr) | rx_done;
         overrun_ff  <= (overrun_ff & ~cmd_clr) |
                        (rx_done & rx_ready_ff & ~rd_rhr);
         par_err_ff  <= (par_err_ff & ~cmd_clr) |
                        (rx_done & par_on & rx_par_bad);
         stop_err_ff <= (stop_err_ff & ~cmd_clr) |
                        (rx_done & ~rxd_in);
         if (rx_done) begin
            rhr_ff <= rx_shift_ff;
         end
      end
   end

   // ***************************************
   // Receiver idle timeout
   // ***************************************
   // Character arrival and commands take priority over counting
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         idle_cnt_ff <= 16'h0000;
         idle_run_ff <= 1'b0;
         idle_exp_ff <= 1'b0;
      end else if (idle_reload_ff == 16'h0000) begin
         idle_run_ff <= 1'b0;
         idle_exp_ff <= 1'b0;
      end else if (rx_done | cmd_reload) begin
         idle_cnt_ff <= idle_reload_ff;
         idle_run_ff <= 1'b1;
         if (cmd_reload) begin
            idle_exp_ff <= 1'b0;
         end
      end else if (cmd_arm) begin
         idle_run_ff <= 1'b0;
         idle_exp_ff <= 1'b0;
      end else if (bit_tick_in & idle_run_ff) begin
         idle_cnt_ff <= idle_cnt_ff - 16'h0001;
         if (idle_cnt_ff == 16'h0001) begin
            idle_exp_ff <= 1'b1;
            idle_run_ff <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// File: verif/upg_usart_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Bus handshake and line timing checks
// ************************************
module upg_usart_monitor (
   // Clock and reset
   input wire logic        core_clk_in,
   input wire logic        reset_in,
   // Serial side
   input wire logic        bit_tick_in,
   input wire logic        txd_out,
   // Write channels
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic [4:0]  s_axi_awaddr_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic [1:0]  s_axi_bresp_out,
   // Read channels
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic [4:0]  s_axi_araddr_in,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0]  s_axi_rresp_out
);
   default clocking dcb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // Write address accepted for one offset
   sequence s_aw(a);
      s_axi_awvalid_in && s_axi_awready_out && s_axi_awaddr_in == a;
   endsequence
   // Response code shortly after
   sequence s_b(r);
      ##[1:4] s_axi_bvalid_out && s_axi_bresp_out == r;
   endsequence
   property p_aw_pulse;
      s_axi_awready_out |=> !s_axi_awready_out; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
   property p_w_pulse;
      s_axi_wready_out |=> !s_axi_wready_out; endproperty
   a_w_pulse: assert property (p_w_pulse) else $error("wready held");
   property p_r_follow;
      s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
   endproperty
   a_r_follow: assert property (p_r_follow) else $error("read data late");
   property p_b_done;
      s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out; endproperty
   a_b_done: assert property (p_b_done) else $error("bvalid stuck");
   property p_r_done;
      s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out; endproperty
   a_r_done: assert property (p_r_done) else $error("rvalid stuck");
   property p_ro_status;
      s_aw(5'h08) |-> s_b(2'h2); endproperty
   a_ro_status: assert property (p_ro_status) else $error("status writable");
   property p_mode_ok;
      s_aw(5'h04) |-> s_b(2'h0); endproperty
   a_mode_ok: assert property (p_mode_ok) else $error("mode write refused");
   property p_rd_unmapped;
      s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 5'h18 |->
      ##[1:3] s_axi_rvalid_out && s_axi_rresp_out == 2'h2 &&
      s_axi_rdata_out == 32'h0000_0000; endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("bad unmapped");
   property p_txd_tick;
      !$stable(txd_out) |-> $past(bit_tick_in) || $past(reset_in); endproperty
   a_txd_tick: assert property (p_txd_tick) else $error("txd off tick");
endmodule
bind upg_usart upg_usart_monitor u_mon (.core_clk_in, .reset_in,
   .bit_tick_in, .txd_out, .s_axi_awvalid_in, .s_axi_awready_out,
   .s_axi_awaddr_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
   .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
   .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);
`default_nettype wire

// File: verif/upg_remote_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Remote serial station
// ************************************
module upg_remote_peer (
   // Clock and bit strobe
   input  wire logic clk_in,
   input  wire logic tick_in,
   // Serial lines and frame format
   input  wire logic txd_in,
   input  wire logic par_en_in,
   output var  logic rxd_out
);
   logic [3:0] st;  // Bit position of incoming frame
   logic [7:0] hi;  // High samples since last stop
   logic [7:0] gap; // Idle run before last frame
   logic [7:0] dat; // Last byte seen
   logic       par; // Last parity bit seen
   logic [7:0] nrx; // Frames seen
   initial begin
      st = 4'h0;
      hi = 8'h00;
      nrx = 8'h00;
      rxd_out = 1'b1;
   end
   // Decode frames from the block, one sample per bit strobe
   always @(posedge clk_in) if (tick_in) begin
      if (st == 4'h0) begin
         if (txd_in) hi <= hi + 8'h01;
         else begin
            gap <= hi;
            st <= 4'h1;
         end
      end else if (st < 4'h9) begin
         dat[st - 4'h1] <= txd_in;
         st <= st + 4'h1;
      end else if (st == 4'h9 && par_en_in) begin
         par <= txd_in;
         st <= 4'hA;
      end else begin
         // Stop sample; idle count restarts behind it
         hi <= 8'h00;
         st <= 4'h0;
         nrx <= nrx + 8'h01;
      end
   end
   // Send one frame; bad parity or stop only when asked
   task automatic send(input logic [7:0] d, input logic pe, p, s);
      int i;
      begin
         @(posedge clk_in iff tick_in);
         rxd_out <= 1'b0;
         for (i = 0; i < 8; i++) begin
            @(posedge clk_in iff tick_in);
            rxd_out <= d[i];
         end
         if (pe) begin
            @(posedge clk_in iff tick_in);
            rxd_out <= p;
         end
         @(posedge clk_in iff tick_in);
         rxd_out <= s;
         @(posedge clk_in iff tick_in);
         rxd_out <= 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "upg_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fails++; $display("wrong value at %0t got %h exp %h", $time, g, e); \
   end end
// ************************************
// Register-level bench
// ************************************
module tb;
   localparam logic [4:0] CT = `UPG_OFF_CTRL;
   localparam logic [4:0] ST = `UPG_OFF_STATUS;
   logic        clk, rst, tick, pe, txd, rxd;  // Clock, line, format
   logic [1:0]  tcnt, resp, br, rr;            // Strobe divider, codes
   logic        awv, awr, wv, wrd, bv, bre;    // Write handshakes
   logic        arv, arr, rv, rre;             // Read handshakes
   logic [4:0]  aa, ra;                        // Addresses
   logic [31:0] wd, rdt;                       // Data
   int          fails, samples_checked, nx, i, g;
   logic [2:0]  pm [7] = '{0, 1, 2, 3, 4, 6, 7}; // Parity codes
   logic        pb [7] = '{0, 1, 0, 1, 0, 0, 0}; // Parity of 0x41
   upg_usart dut (.core_clk_in(clk), .reset_in(rst), .bit_tick_in(tick),
      .rxd_in(rxd), .txd_out(txd), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_awaddr_in(aa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_araddr_in(ra), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
      .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr));
   upg_remote_peer peer (.clk_in(clk), .tick_in(tick), .txd_in(txd),
      .par_en_in(pe), .rxd_out(rxd));
   always #4 clk = ~clk;
   // Bit strobe every fourth cycle keeps frames short
   always @(posedge clk) begin
      tcnt <= tcnt + 2'h1;
      tick <= tcnt == 2'h3;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic hang;
      fails++;
      give_verdict();
   endtask
   // Write one word; bready stays up until the response
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk);
         aa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
         do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
         end while (!bv && n < 100);
         bre <= 0;
         resp = br;
         if (n >= 100) hang();
      end
   endtask
   // Read one word and compare the masked value
   task automatic rd(input logic [4:0] a, input logic [31:0] m, e);
      int n;
      begin
         n = 0;
         @(posedge clk);
         ra <= a; arv <= 1; rre <= 1;
         do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 0;
         end while (!rv && n < 100);
         rre <= 0;
         resp = rr;
         `CHK(rdt & m, e)
         if (n >= 100) hang();
      end
   endtask
   // Wait for the peer to count another frame
   task automatic next_rx;
      int n;
      begin
         nx++;
         for (n = 0; peer.nrx != nx[7:0] && n < 2000; n++) @(posedge clk);
         if (n >= 2000) hang();
      end
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge clk iff tick);
   endtask
   initial begin
      {clk, tick, tcnt, awv, wv, bre, arv, rre, pe, aa, ra, wd} = 0;
      rst = 1;
      repeat (8) @(posedge clk);
      rst <= 0;
      rd(ST, 32'h7f, 32'h42);
      rd(`UPG_OFF_MODE, 32'h7, `UPG_RST_MODE);
      rd(5'h1c, 32'hffff_ffff, 0);
      `CHK(resp, `UPG_RESP_SLVERR)
      wr(ST, 0);
      `CHK(resp, `UPG_RESP_SLVERR)
      wr(`UPG_OFF_MODE, 0);
      pe <= 1;
      peer.send(8'h41, 1, 0, 1);
      rd(ST, 32'h1d, 32'h01);
      peer.send(8'h5a, 1, 0, 1);
      rd(ST, 32'h1d, 32'h05);
      rd(`UPG_OFF_RHR, 32'hff, 32'h5a);
      wr(CT, 1);
      rd(ST, 32'h1d, 0);
      peer.send(8'h41, 1, 0, 0);
      rd(ST, 32'h08, 32'h08);
      wr(CT, 1);
      rd(ST, 32'h08, 0);
      // Each parity code: send, then bad and good receive
      for (i = 0; i < 7; i++) begin
         wr(`UPG_OFF_MODE, {29'h0, pm[i]});
         pe <= pm[i] != `UPG_PAR_NONE;
         wr(CT, 1);
         wr(`UPG_OFF_THR, 32'h41);
         next_rx();
         `CHK(peer.dat, 8'h41)
         if (pe) `CHK(peer.par, pb[i])
         peer.send(8'h41, pe, !pb[i], 1);
         peer.send(8'h41, pe, pb[i], 1);
         rd(ST, 32'h10, pe ? 32'h10 : 0);
      end
      wr(CT, 2);
      wr(`UPG_OFF_THR, 32'h41);
      next_rx();
      `CHK(peer.par, 1'b1)
      wr(`UPG_OFF_THR, 32'h41);
      next_rx();
      `CHK(peer.par, 1'b0)
      wr(`UPG_OFF_MODE, 4);
      pe <= 0;
      wr(`UPG_OFF_GUARD, 32'h1ff);
      rd(`UPG_OFF_GUARD, 32'hffff_ffff, 32'hff);
      // Two bytes back to back, with and without guard time
      for (g = 5; g >= 0; g -= 5) begin
         wr(`UPG_OFF_GUARD, g);
         wr(`UPG_OFF_THR, 1);
         ticks(2);
         wr(`UPG_OFF_THR, 2);
         next_rx();
         rd(ST, 32'h42, g ? 0 : 32'h02);
         next_rx();
         `CHK(peer.gap, g[7:0])
         ticks(g + 2);
         rd(ST, 32'h42, 32'h42);
      end
      wr(`UPG_OFF_IDLE, 32'h1_ffff);
      rd(`UPG_OFF_IDLE, 32'hffff_ffff, 32'hffff);
      wr(`UPG_OFF_IDLE, 3);
      wr(CT, 8);
      ticks(5);
      rd(ST, 32'h20, 32'h20);
      wr(CT, 4);
      ticks(8);
      rd(ST, 32'h20, 0);
      peer.send(8'h11, 0, 0, 1);
      rd(ST, 32'h20, 0);
      ticks(4);
      rd(ST, 32'h20, 32'h20);
      wr(`UPG_OFF_IDLE, 0);
      wr(CT, 8);
      ticks(8);
      rd(ST, 32'h20, 0);
      give_verdict();
   end
endmodule
`default_nettype wire
